// ===== core/ee_pkg.sv
// Shared constants, types and helpers of the serial memory slave port
package ee_pkg;
  // Array geometry
  localparam int PAGE_BYTES = 32;
  localparam int NUM_PAGES  = 128;
  localparam int ARR_BYTES  = PAGE_BYTES * NUM_PAGES;
  localparam int ADDR_W     = 12;
  // Device type codes in the upper nibble of the address byte
  localparam logic [3:0] DEV_MEM = 4'hA;
  localparam logic [3:0] DEV_AUX = 4'hB;
  // Word address bits that steer auxiliary accesses
  localparam int WA_UID_BIT  = 11;
  localparam int WA_LOCK_BIT = 10;
  // Bit counter positions within a nine-clock byte slot
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;
  // Reset values
  localparam logic FRM_CLR_RST = 1'b1;
  localparam logic LOCK_RST    = 1'b0;
  // Programming time and its cycle count at the reference clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROG_TIME_NS  = 3_000_000;
  localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  // Serial number contents; value is arbitrary
  localparam logic [127:0] UID_VALUE = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;

  typedef enum logic [1:0] {
    SEL_ARR  = 2'b00,
    SEL_ID   = 2'b01,
    SEL_LOCK = 2'b10,
    SEL_UID  = 2'b11
  } ee_sel_t;

  typedef enum logic [2:0] {
    ST_DEV = 3'b000,
    ST_AHI = 3'b001,
    ST_ALO = 3'b010,
    ST_WD  = 3'b011,
    ST_RD  = 3'b100,
    ST_IGN = 3'b101
  } ee_lst_t;

  // Next address; writes, ID page and serial number wrap inside their block; the lock address holds
  function automatic logic [ADDR_W-1:0] ee_bump(input logic [ADDR_W-1:0] a,
                                               input ee_sel_t s, input logic in_page);
    logic [ADDR_W-1:0] n;
    n = a + 12'h001;
    if (s == SEL_LOCK)
      n = a;
    else if (s == SEL_UID)
      n = {a[11:4], n[3:0]};
    else if (in_page || s == SEL_ID)
      n = {a[11:5], n[4:0]};
    return n;
  endfunction
endpackage

// ===== core/ee_nvm_if.sv
// Link between the serial front end and the nonvolatile store
`timescale 1ns/10ps
interface ee_nvm_if;
  import ee_pkg::*;
  ee_sel_t     sel;
  logic [11:0] addr;
  logic [7:0]  rd_data;
  logic        go;
  logic [4:0]  buf_idx;
  logic [7:0]  buf_byte;
  logic        buf_vld;
  logic        busy;
  logic        locked;
  modport port (output sel, addr, go, buf_byte, buf_vld,
                input rd_data, buf_idx, busy, locked);
  modport nvm (input sel, addr, go, buf_byte, buf_vld,
               output rd_data, buf_idx, busy, locked);
endinterface

// ===== core/ee_nvm.sv
// Nonvolatile store: array, identification page, serial number, write timer
`timescale 1ns/10ps
module ee_nvm import ee_pkg::*; #(
  parameter int             PROG_CYC = PROG_CYCLES,
  parameter logic [127:0]   UID      = UID_VALUE
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Front end
  ee_nvm_if.nvm    nv
);
  localparam int TW = $clog2(PROG_CYC + 1);

  // (R1) 128 pages of 32 bytes
  logic [7:0]    arr_m [0:ARR_BYTES-1];
  logic [7:0]    id_m  [0:PAGE_BYTES-1];
  logic          lock_r;
  logic          busy_r;
  logic          copy_r;
  logic [4:0]    idx_r;
  ee_sel_t       kind_r;
  logic [TW-1:0] tmr_r;
  logic [TW:0]   blen_r;
  logic [127:0]  uid_sh;
  logic          start_w;

  assign start_w = nv.go && !busy_r;

  ////////////////////////////////////////////////////////////////////////////
  // Copy of the page buffer, one byte a cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      copy_r <= 1'b0;
      idx_r  <= 5'h00;
      kind_r <= SEL_ARR;
    end else if (start_w) begin
      copy_r <= (nv.sel == SEL_ARR) || (nv.sel == SEL_ID);
      idx_r  <= 5'h00;
      kind_r <= nv.sel;
    end else if (copy_r) begin
      idx_r <= idx_r + 5'h01;
      if (idx_r == 5'h1F)
        copy_r <= 1'b0;
    end
  end

  // (R4) locked page takes no data
  always_ff @(posedge ref_clk) begin
    if (copy_r && nv.buf_vld && kind_r == SEL_ARR)
      arr_m[{nv.addr[11:5], idx_r}] <= nv.buf_byte;
    if (copy_r && nv.buf_vld && kind_r == SEL_ID && !lock_r)
      id_m[idx_r] <= nv.buf_byte;
  end

  // (R4) lock is one-way
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      lock_r <= LOCK_RST;
    else if (start_w && nv.sel == SEL_LOCK)
      lock_r <= 1'b1;
  end

  // (R3) self-timed cycle, bounded
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      tmr_r  <= '0;
    end else if (start_w) begin
      busy_r <= 1'b1;
      tmr_r  <= '0;
    end else if (busy_r) begin
      if (tmr_r == TW'(PROG_CYC - 1))
        busy_r <= 1'b0;
      else
        tmr_r <= tmr_r + TW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port; contents only change while the front end refuses access
  always_comb begin
    uid_sh = UID >> {~nv.addr[3:0], 3'b000};
    case (nv.sel)
      SEL_ARR:  nv.rd_data = arr_m[nv.addr];
      SEL_ID:   nv.rd_data = id_m[nv.addr[4:0]];
      SEL_LOCK: nv.rd_data = {7'h00, lock_r};
      default:  nv.rd_data = uid_sh[7:0];
    endcase
  end

  assign nv.buf_idx = idx_r;
  assign nv.busy    = busy_r;
  assign nv.locked  = lock_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      blen_r <= '0;
    else
      blen_r <= busy_r ? blen_r + (TW+1)'(1) : '0;
  end

  prog_bound_a: assert property ( // (R3)
    @(posedge ref_clk) disable iff (rst) blen_r <= (TW+1)'(PROG_CYC))
    else $error("programming cycle overran its limit");
  copy_len_a: assert property ( // (R2)
    @(posedge ref_clk) disable iff (rst) $rose(copy_r) |-> ##31 copy_r ##1 !copy_r)
    else $error("page copy did not take 32 cycles");
  lock_keep_a: assert property ( // (R4)
    @(posedge ref_clk) disable iff (rst)
    lock_r |=> lock_r && !(copy_r && kind_r == SEL_ID && nv.buf_vld))
    else $error("locked page changed");
endmodule // ee_nvm

// ===== core/ee_slave_port.sv
// Two-wire serial slave port of a 32-Kbit nonvolatile memory
//
// Functional notes
// (R1) Main array is 128 pages of 32 bytes, 4096 bytes.
// (R2) Single bytes, full pages and partial pages are all written.
// (R3) Internal programming runs self-timed and ends within 3 ms.
// (R4) Extra 32-byte ID page; once locked it refuses every write.
// (R5) 128-bit serial number is read-only, reached only by its read command.
// (R6) Three strapped select inputs let eight devices share the bus.
// (R7) An unconnected select input reads as low.
// (R8) Data line is driven only low, open-drain, for both directions.
// (R9) Bits sampled on clock rise, own bits changed on clock fall.
// (R10) Write protect high blocks writes; low allows them.
// (R11) Unconnected write protect reads as low, writes enabled.
// (R12) Under protection address bytes are acked, data bytes are not.
// (R13) Bytes go MSB first over eight clocks, ack on the ninth.
// (R14) Type 1010 selects the array, 1011 the ID page or serial number.
// (R15) Stop after a write starts programming; any other stop gives standby.
// (R16) Two word address bytes follow, high byte first, each acked.
// (R17) No ack to the address byte while programming runs.
// (R18) Page write addresses wrap within the current 32-byte page.
`timescale 1ns/10ps
module ee_slave_port import ee_pkg::*; #(
  parameter int PROG_CYC = PROG_CYCLES
) (
  // Clocks and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic scl,
  // Serial data pin
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Straps
  input  wire logic chip_select_bit_low,
  input  wire logic chip_select_bit_mid,
  input  wire logic chip_select_bit_high,
  input  wire logic write_protect,
  // Status
  output logic      prog_busy,
  output logic      id_locked
);

  ee_nvm_if nv ();

  // Reference clock domain
  logic       scl_q1_r;
  logic       scl_q2_r;
  logic [2:0] scl_h_r;
  logic       sda_q1_r;
  logic       sda_q2_r;
  logic       sda_d_r;
  logic       pend_q1_r;
  logic       pend_q2_r;
  logic       frm_clr_r;
  logic       go_r;
  logic       busy_out_r;
  logic       lock_out_r;
  logic       sda_zero_r;
  logic       start_w;
  logic       stop_w;

  // Link clock domain
  logic [2:0] cs_q1_r;
  logic [2:0] cs_q2_r;
  logic       wp_q1_r;
  logic       wp_q2_r;
  logic       busy_q1_r;
  logic       busy_q2_r;
  logic       lock_q1_r;
  logic       lock_q2_r;
  logic [7:0] sh_r;
  logic       nack_r;
  logic [3:0] bit_r;
  ee_lst_t    st_r;
  ee_lst_t    st_nxt;
  logic       sda_oe_r;
  logic [7:0] tx_r;
  logic [7:0] hi_r;
  logic [11:0] addr_r;
  ee_sel_t    sel_r;
  logic       typ_r;
  logic       pend_r;
  logic [31:0] mask_r;
  logic [7:0] pbuf_m [0:PAGE_BYTES-1];
  logic       dev_hit;
  logic       wr_ok;
  logic       ack_w;
  logic       byte_end;

  ////////////////////////////////////////////////////////////////////////////
  // Bus condition detection on the reference clock

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_q1_r  <= 1'b1;
      scl_q2_r  <= 1'b1;
      scl_h_r   <= 3'h7;
      sda_q1_r  <= 1'b1;
      sda_q2_r  <= 1'b1;
      sda_d_r   <= 1'b1;
      pend_q1_r <= 1'b0;
      pend_q2_r <= 1'b0;
    end else begin
      scl_q1_r  <= scl;
      scl_q2_r  <= scl_q1_r;
      scl_h_r   <= {scl_h_r[1:0], scl_q2_r};
      sda_q1_r  <= sda_in;
      sda_q2_r  <= sda_q1_r;
      sda_d_r   <= sda_q2_r;
      pend_q1_r <= pend_r;
      pend_q2_r <= pend_q1_r;
    end
  end
  // Frame edges need the clock seen high on four samples, so fast data bits never alias
  assign start_w = (&scl_h_r) && scl_q2_r && sda_d_r && !sda_q2_r;
  assign stop_w  = (&scl_h_r) && scl_q2_r && !sda_d_r && sda_q2_r;
  // (R15) stop returns the link to standby
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      frm_clr_r <= FRM_CLR_RST;
    else if (start_w || stop_w)
      frm_clr_r <= 1'b1;
    else if (!scl_q2_r)
      frm_clr_r <= 1'b0;
  end
  // (R15) stop after a write starts programming
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      go_r <= 1'b0;
    else
      go_r <= stop_w && pend_q2_r && !nv.busy;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_out_r <= 1'b0;
      lock_out_r <= 1'b0;
      sda_zero_r <= 1'b0;
    end else begin
      busy_out_r <= nv.busy;
      lock_out_r <= nv.locked;
      sda_zero_r <= 1'b0;
    end
  end
  // (R8) pin only ever pulled low
  assign sda_out   = sda_zero_r;
  assign sda_oe    = sda_oe_r;
  assign prog_busy = busy_out_r;
  assign id_locked = lock_out_r;

  ////////////////////////////////////////////////////////////////////////////
  // Strap and status synchronisers on the link clock

  // (R7) floating straps are pulled low at the pad
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      cs_q1_r   <= 3'h0;
      cs_q2_r   <= 3'h0;
      wp_q1_r   <= 1'b0;
      wp_q2_r   <= 1'b0;
      busy_q1_r <= 1'b0;
      busy_q2_r <= 1'b0;
      lock_q1_r <= 1'b0;
      lock_q2_r <= 1'b0;
    end else begin
      cs_q1_r   <= {chip_select_bit_high, chip_select_bit_mid, chip_select_bit_low};
      cs_q2_r   <= cs_q1_r;
      // (R11) floating protect reads low
      wp_q1_r   <= write_protect;
      wp_q2_r   <= wp_q1_r;
      busy_q1_r <= nv.busy;
      busy_q2_r <= busy_q1_r;
      lock_q1_r <= nv.locked;
      lock_q2_r <= lock_q1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine on the link clock

  // (R9) sample on the rising edge
  always_ff @(posedge scl or posedge frm_clr_r) begin
    if (frm_clr_r) begin
      sh_r   <= 8'h00;
      nack_r <= 1'b0;
    end else if (bit_r == BIT_ACK) begin
      nack_r <= sda_in;
    end else begin
      // (R13) most significant bit first
      sh_r <= {sh_r[6:0], sda_in};
    end
  end
  assign byte_end = (bit_r == BIT_LAST);
  // (R14) type code and (R6) strap match
  assign dev_hit = (sh_r[7:4] == DEV_MEM || sh_r[7:4] == DEV_AUX)
                   && sh_r[3:1] == cs_q2_r && !busy_q2_r;

  // (R10) protect and (R4) lock refuse data; (R5) serial number never written
  assign wr_ok = !wp_q2_r && sel_r != SEL_UID
                 && !((sel_r == SEL_ID || sel_r == SEL_LOCK) && lock_q2_r);

  always_comb begin
    ack_w  = 1'b0;
    st_nxt = st_r;
    case (st_r)
      ST_DEV: begin
        // (R17) busy device stays silent
        ack_w  = dev_hit;
        st_nxt = !dev_hit ? ST_IGN : (sh_r[0] ? ST_RD : ST_AHI);
      end
      ST_AHI: begin
        // (R16) both word bytes acked
        ack_w  = 1'b1;
        st_nxt = ST_ALO;
      end
      ST_ALO: begin
        ack_w  = 1'b1;
        st_nxt = ST_WD;
      end
      // (R12) data acked only when writable
      ST_WD:   ack_w = wr_ok;
      default: ack_w = 1'b0;
    endcase
  end

  // (R9) own bits change on the falling edge
  always_ff @(negedge scl or posedge frm_clr_r) begin
    if (frm_clr_r) begin
      bit_r    <= BIT_FIRST;
      st_r     <= ST_DEV;
      sda_oe_r <= 1'b0;
      tx_r     <= 8'h00;
    end else if (byte_end) begin
      // (R13) ninth clock carries the answer
      bit_r    <= BIT_ACK;
      sda_oe_r <= ack_w;
      st_r     <= st_nxt;
    end else if (bit_r == BIT_ACK) begin
      bit_r <= BIT_FIRST;
      if (st_r == ST_RD && !nack_r) begin
        tx_r     <= nv.rd_data;
        sda_oe_r <= !nv.rd_data[7];
      end else begin
        sda_oe_r <= 1'b0;
        if (st_r == ST_RD)
          st_r <= ST_IGN;
      end
    end else begin
      bit_r    <= bit_r + 4'h1;
      tx_r     <= {tx_r[6:0], 1'b0};
      sda_oe_r <= (st_r == ST_RD) && !tx_r[6];
    end
  end

  // Address, selection and write bookkeeping survive repeated starts
  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      hi_r   <= 8'h00;
      addr_r <= 12'h000;
      sel_r  <= SEL_ARR;
      typ_r  <= 1'b0;
      pend_r <= 1'b0;
      mask_r <= 32'h0000_0000;
    end else if (byte_end && !frm_clr_r) begin
      case (st_r)
        ST_DEV: begin
          pend_r <= 1'b0;
          if (dev_hit) begin
            typ_r  <= sh_r[4];
            if (sh_r[0] && sh_r[7:4] == DEV_MEM)
              sel_r <= SEL_ARR;
          end
        end
        ST_AHI: hi_r <= sh_r;
        ST_ALO: begin
          addr_r <= {hi_r[3:0], sh_r};
          mask_r <= 32'h0000_0000;
          if (!typ_r)
            sel_r <= SEL_ARR;
          else if (hi_r[WA_UID_BIT-8])
            sel_r <= SEL_UID;
          else if (hi_r[WA_LOCK_BIT-8])
            sel_r <= SEL_LOCK;
          else
            sel_r <= SEL_ID;
        end
        ST_WD: begin
          if (wr_ok) begin
            mask_r[addr_r[4:0]] <= 1'b1;
            pend_r              <= 1'b1;
            // (R18) wrap inside the page
            addr_r              <= ee_bump(addr_r, sel_r, 1'b1);
          end
        end
        ST_RD:   addr_r <= ee_bump(addr_r, sel_r, 1'b0);
        default: addr_r <= addr_r;
      endcase
    end
  end

  // (R2) partial pages keep a byte mask
  always_ff @(negedge scl) begin
    if (byte_end && !frm_clr_r && st_r == ST_WD && wr_ok)
      pbuf_m[addr_r[4:0]] <= sh_r;
  end

  // Buffer and selection are static after the stop that commits them
  assign nv.sel      = sel_r;
  assign nv.addr     = addr_r;
  assign nv.go       = go_r;
  assign nv.buf_byte = pbuf_m[nv.buf_idx];
  assign nv.buf_vld  = mask_r[nv.buf_idx];

  ee_nvm #(
    .PROG_CYC (PROG_CYC)
  ) u_nvm (
    .ref_clk (ref_clk),
    .rst     (rst),
    .nv      (nv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  dev_ack_a: assert property ( // (R14)
    @(negedge scl) disable iff (frm_clr_r)
    (byte_end && st_r == ST_DEV && dev_hit) |=> sda_oe_r && bit_r == BIT_ACK)
    else $error("matching address byte not acked");
  cs_miss_a: assert property ( // (R6)
    @(negedge scl) disable iff (frm_clr_r)
    (byte_end && st_r == ST_DEV && sh_r[3:1] != cs_q2_r) |=> !sda_oe_r ##1 st_r == ST_IGN)
    else $error("foreign address byte answered");
  busy_nack_a: assert property ( // (R17)
    @(negedge scl) disable iff (frm_clr_r)
    (byte_end && st_r == ST_DEV && busy_q2_r) |=> !sda_oe_r)
    else $error("address acked while programming");
  addr_ack_a: assert property ( // (R16)
    @(negedge scl) disable iff (frm_clr_r)
    (byte_end && st_r == ST_AHI) |=> sda_oe_r ##9 (sda_oe_r && st_r == ST_WD))
    else $error("word address bytes not acked");
  wp_nack_a: assert property ( // (R12)
    @(negedge scl) disable iff (frm_clr_r)
    (byte_end && st_r == ST_WD && wp_q2_r) |=> !sda_oe_r && $stable(mask_r))
    else $error("protected data byte acked or stored");
  uid_ro_a: assert property ( // (R5)
    @(negedge scl) disable iff (frm_clr_r)
    (byte_end && st_r == ST_WD && sel_r == SEL_UID) |=> !sda_oe_r && !pend_r)
    else $error("serial number accepted a write");
  page_wrap_a: assert property ( // (R18)
    @(negedge scl) disable iff (rst)
    (byte_end && !frm_clr_r && st_r == ST_WD && wr_ok && sel_r != SEL_LOCK)
    |=> addr_r[11:5] == $past(addr_r[11:5]) && addr_r[4:0] == $past(addr_r[4:0]) + 5'h01)
    else $error("page write left its page");
  ack_free_a: assert property ( // (R13)
    @(negedge scl) disable iff (frm_clr_r)
    (bit_r == BIT_ACK && st_r != ST_RD) |=> !sda_oe_r && bit_r == BIT_FIRST)
    else $error("data line held after answer slot");
  stop_idle_a: assert property ( // (R15)
    @(posedge ref_clk) disable iff (rst)
    stop_w |=> frm_clr_r)
    else $error("stop did not return to standby");
  commit_a: assert property ( // (R15)
    @(posedge ref_clk) disable iff (rst)
    (stop_w && pend_q2_r && !nv.busy) |=> go_r ##1 (nv.busy && !go_r))
    else $error("write stop did not start programming");
endmodule // ee_slave_port

// ===== tb/ee_master.sv
// Behavioural two-wire bus master that drives the slave port
`timescale 1ns/10ps
module ee_master (
  // Bus lines
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // Clock stands high and data is released outside frames
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Start or repeated start, with long setup and hold for the detector
  task automatic start();
    if (!scl) begin
      #4 sda_pull = 1'b0;
      #12 scl = 1'b1;
    end
    #160 sda_pull = 1'b1;
    #160 scl = 1'b0;
    #200;
  endtask

  task automatic stop();
    #4 sda_pull = 1'b1;
    #12 scl = 1'b1;
    #160 sda_pull = 1'b0;
    #160;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // data changes while low, MSB first, ack sampled on ninth rise
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #4 sda_pull = ~b[i];
      #12 scl = 1'b1;
      #16 scl = 1'b0;
    end
    #4 sda_pull = 1'b0;
    #12 scl = 1'b1;
    ack = sda;
    #16 scl = 1'b0;
  endtask

  // bits taken on rise, ack or nack given on ninth clock
  task automatic get(output logic [7:0] b, input logic ack_it);
    for (int i = 7; i >= 0; i--) begin
      #16 scl = 1'b1;
      b[i] = sda;
      #16 scl = 1'b0;
    end
    #4 sda_pull = ack_it;
    #12 scl = 1'b1;
    #16 scl = 1'b0;
    #4 sda_pull = 1'b0;
  endtask
endmodule // ee_master

// ===== tb/serial_eeprom_slave_port_test.sv
// Self-checking bench of the serial memory slave port
`timescale 1ns/10ps
module serial_eeprom_slave_port_test;
  import ee_pkg::*;
  localparam int P = 64;
  logic       ref_clk = 1'b0;
  logic       rst     = 1'b1;
  logic [2:0] cs      = 3'h0;
  logic       wp      = 1'b0;
  logic       scl;
  logic       m_pull;
  logic       sda_out;
  logic       sda_oe;
  logic       prog_busy;
  logic       id_locked;
  wire logic  sda;
  int         n_errors = 0;
  int         n_checks = 0;
  int         bcnt     = 0;

  always #12.5 ref_clk = ~ref_clk;
  // Wired-and data line with pull-up
  assign sda = ~((sda_oe & ~sda_out) | m_pull);

  ee_master m (.scl(scl), .sda_pull(m_pull), .sda(sda));

  ee_slave_port #(.PROG_CYC(P)) DUT (
    .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_select_bit_low(cs[0]), .chip_select_bit_mid(cs[1]),
    .chip_select_bit_high(cs[2]), .write_protect(wp), .prog_busy(prog_busy),
    .id_locked(id_locked));

  always @(posedge ref_clk) if (prog_busy === 1'b1) bcnt <= bcnt + 1;

  always @(posedge ref_clk) begin
    if (sda_oe === 1'b1 && sda_out !== 1'b0) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, sda_out, 1'b0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic head(input logic [3:0] typ, input logic [11:0] wa);
    logic a;
    m.start();
    m.put({typ, cs, 1'b0}, a);
    chk(8'(a), 8'h00);
    m.put({4'h0, wa[11:8]}, a);
    chk(8'(a), 8'h00);
    m.put(wa[7:0], a);
    chk(8'(a), 8'h00);
  endtask

  task automatic wr(input logic [3:0] typ, input logic [11:0] wa, input logic [7:0] d[$],
                    input logic nack);
    logic a;
    head(typ, wa);
    foreach (d[i]) begin
      m.put(d[i], a);
      chk(8'(a), 8'(nack));
    end
    m.stop();
  endtask

  task automatic rd(input logic [3:0] typ, input logic [11:0] wa, input logic [7:0] e[$]);
    logic       a;
    logic [7:0] b;
    head(typ, wa);
    m.start();
    m.put({typ, cs, 1'b1}, a);
    chk(8'(a), 8'h00);
    foreach (e[i]) begin
      m.get(b, i != e.size() - 1);
      chk(b, e[i]);
    end
    m.stop();
  endtask

  task automatic probe(input logic [7:0] ab, input logic nack);
    logic a;
    m.start();
    m.put(ab, a);
    chk(8'(a), 8'(nack));
    m.stop();
  endtask

  // Waits out any programming cycle, bounded
  task automatic settle();
    for (int k = 0; k < 12 && prog_busy !== 1'b1; k++) @(posedge ref_clk);
    for (int k = 0; prog_busy === 1'b1; k++) begin
      if (k > P + 8) begin
        n_errors++;
        $display("MISMATCH t=%0t got %h exp %h", $time, k, P);
        complete_run();
      end
      @(posedge ref_clk);
    end
    repeat (2) @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_addr();
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk) cs <= 3'(k);
      @(posedge ref_clk);
      probe({DEV_MEM, 3'(k), 1'b0}, 1'b0);
      probe({DEV_AUX, 3'(k), 1'b0}, 1'b0);
      probe({DEV_MEM, 3'(k) ^ 3'h5, 1'b0}, 1'b1);
      probe({4'h9, 3'(k), 1'b0}, 1'b1);
    end
    $display("test addressing finished");
  endtask

  task automatic t_page();
    @(posedge ref_clk) bcnt <= 0;
    wr(DEV_MEM, 12'h03E, '{8'hA0, 8'hA1, 8'hA2, 8'hA3}, 1'b0);
    probe({DEV_MEM, cs, 1'b0}, 1'b1);
    settle();
    chk(8'(bcnt > 0 && bcnt <= P + 1), 8'h01);
    rd(DEV_MEM, 12'h03E, '{8'hA0, 8'hA1});
    rd(DEV_MEM, 12'h020, '{8'hA2, 8'hA3});
    $display("test page finished");
  endtask

  task automatic t_protect();
    wr(DEV_MEM, 12'h100, '{8'h11}, 1'b0);
    settle();
    @(posedge ref_clk) wp <= 1'b1;
    wr(DEV_MEM, 12'h100, '{8'h5A}, 1'b1);
    settle();
    rd(DEV_MEM, 12'h100, '{8'h11});
    wr(DEV_AUX, 12'h400, '{8'hFF}, 1'b1);
    settle();
    @(posedge ref_clk) wp <= 1'b0;
    chk(8'(id_locked), 8'h00);
    $display("test protect finished");
  endtask

  task automatic t_idpage();
    logic [7:0] u[$];
    wr(DEV_AUX, 12'h01F, '{8'hC3, 8'h3C}, 1'b0);
    settle();
    rd(DEV_AUX, 12'h01F, '{8'hC3, 8'h3C});
    rd(DEV_AUX, 12'h400, '{8'h00});
    wr(DEV_AUX, 12'h400, '{8'hFF}, 1'b0);
    settle();
    chk(8'(id_locked), 8'h01);
    wr(DEV_AUX, 12'h01F, '{8'h00}, 1'b1);
    settle();
    rd(DEV_AUX, 12'h01F, '{8'hC3});
    rd(DEV_AUX, 12'h400, '{8'h01});
    for (int i = 0; i <= 16; i++) u.push_back(UID_VALUE[127 - 8 * (i % 16) -: 8]);
    rd(DEV_AUX, 12'h800, u);
    wr(DEV_AUX, 12'h800, '{8'h00}, 1'b1);
    $display("test id and serial finished");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_addr();
    t_page();
    t_protect();
    t_idpage();
    complete_run();
  end
endmodule // serial_eeprom_slave_port_test
